/* status_msg_pkg.sv */
// Package: constants for the completion status message builder.
// Assumes byte-serial transmit toward the transport layer.
package status_msg_pkg;
   // ************************************************************
   // Message layout
   // ************************************************************
   localparam logic [7:0] MSG_CODE        = 8'h83;
   localparam logic [7:0] PROTOCOL_SUBCODE = 8'h11;
   localparam logic [7:0] RC_PARSED_OK    = 8'h00;
   localparam logic [7:0] RC_INVALID_FIELD = 8'hFF;
   localparam logic [7:0] CHECK_CONDITION = 8'h02;
   localparam logic [7:0] ERR_CODE_CURRENT = 8'h70;
   localparam logic [7:0] ERR_CODE_DEFERRED = 8'h71;
   localparam logic [5:0] SHORT_LEN       = 6'h08;
   localparam logic [5:0] FULL_LEN        = 6'h20;
   localparam logic [4:0] SENSE_BYTES     = 5'h18;
   localparam logic [7:0] SENSE_FIT_LIMIT = 8'h10;
   localparam int         TAG_W           = 16;
   localparam int         PATH_W          = 32;
endpackage : status_msg_pkg

/* status_byte_mux.sv */
// Byte selector: picks one byte of the status message by index.
// Assumes all fields are held stable by the caller during a frame.
`timescale 1ns/1ps
module status_byte_mux
   import status_msg_pkg::*;
(
   input  wire logic [5:0]             idx,
   input  wire logic [15:0]            tag,
   input  wire logic [7:0]             status,
   input  wire logic                   flag,
   input  wire logic                   link,
   input  wire logic [7:0]             ret_code,
   input  wire logic [SENSE_BYTES*8-1:0] sense,
   output logic      [7:0]             byte_out
);
   wire       in_sense = (idx >= SHORT_LEN);
   wire [4:0] sidx     = 5'(idx - SHORT_LEN);
   always_comb begin
      byte_out = 8'h00;
      unique case (idx)
         6'h00: byte_out = MSG_CODE;
         6'h01: byte_out = PROTOCOL_SUBCODE;
         6'h02: byte_out = tag[15:8];
         6'h03: byte_out = tag[7:0];
         6'h04: byte_out = status;
         6'h05: byte_out = {6'h00, flag, link};
         6'h06: byte_out = ret_code;
         6'h07: byte_out = 8'h00;
         default:
            if (in_sense && sidx < SENSE_BYTES) begin
               byte_out = sense[(SENSE_BYTES-1-sidx)*8 +: 8];
            end
      endcase
   end
endmodule : status_byte_mux

/* status_msg_builder.sv */
// Builder for the completion status message closing each command task.
// Assumes the protocol layer pulses cmd_done per finished command and the
// transport accepts one byte per tx_valid & tx_ready.
`timescale 1ns/1ps
// Summary of operation
// - Send status once command and data finish
// - Route by command's return path identifier
// - One status per command; none if rejected
// - No status for cleared or reset commands
// - Bytes 0,1 carry 83h and 11h
// - Bytes 2,3 copy command tag
// - Byte 4 holds SCSI status
// - Byte 5 flag/link; flag1 link0 never sent
// - Return code 00h or FFh only
// - Non check-condition may be 8 bytes
// - Clear sense on check condition when sense length below 16
// - Sense bytes 8-31; byte 7 reserved
// - Byte 8 valid plus 70h/71h code
// - Byte 10 filemark, medium, length, key
// - Flag bit copies control byte flag when link is set
// - Out-of-order plus confirm gives invalid field
module status_msg_builder
   import status_msg_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic                cmd_done,
   input  wire logic                cmd_rejected,
   input  wire logic                cmd_cleared,
   input  wire logic                hard_reset,
   input  wire logic [TAG_W-1:0]    cmd_tag,
   input  wire logic [PATH_W-1:0]   cmd_return_path,
   input  wire logic [7:0]          cmd_status,
   input  wire logic                ctl_flag,
   input  wire logic                ctl_link,
   input  wire logic                out_of_order,
   input  wire logic                confirm_req,
   input  wire logic                field_invalid,
   input  wire logic                short_enable,
   input  wire logic                sense_valid,
   input  wire logic                sense_deferred,
   input  wire logic [7:0]          segment_number,
   input  wire logic                filemark,
   input  wire logic                end_of_medium_bit,
   input  wire logic                incorrect_length_indicator,
   input  wire logic [3:0]          sense_key,
   input  wire logic [31:0]         information,
   input  wire logic [7:0]          add_sense_length,
   input  wire logic [127:0]        sense_tail,
   input  wire logic                tx_ready,
   output logic                     cmd_ready,
   output logic                     tx_valid,
   output logic [7:0]               tx_data,
   output logic                     tx_last,
   output logic [PATH_W-1:0]        tx_return_path,
   output logic                     sense_clear
);
   // ************************************************************
   // Frame capture
   // ************************************************************
   typedef enum logic [0:0] {IDLE, SEND} state_e;
   state_e                 state;
   logic [TAG_W-1:0]       tag;
   logic [7:0]             status;
   logic                   flag;
   logic                   link;
   logic [7:0]             ret_code;
   logic [SENSE_BYTES*8-1:0] sense;
   logic [5:0]             idx;
   logic [5:0]             len;
   logic                   clear_after;
   logic [7:0]             mux_byte;

   // Rejected or cleared commands never start a frame
   wire accept = (state == IDLE) && cmd_done && !cmd_rejected
                 && !cmd_cleared && !hard_reset;
   wire bad_field = field_invalid
                    || (out_of_order && confirm_req);
   wire [7:0] next_ret_code = bad_field ? RC_INVALID_FIELD
                                        : RC_PARSED_OK;
   // Flag without link is a reserved encoding; suppress the flag then
   wire next_flag = ctl_flag && ctl_link;
   wire is_check  = (cmd_status == CHECK_CONDITION);
   wire [5:0] next_len = (short_enable && !is_check)
                         ? SHORT_LEN : FULL_LEN;
   wire [7:0] err_code = sense_deferred ? ERR_CODE_DEFERRED
                                        : ERR_CODE_CURRENT;
   wire [SENSE_BYTES*8-1:0] next_sense = {
      sense_valid, err_code[6:0],
      segment_number,
      filemark, end_of_medium_bit,
      incorrect_length_indicator, 1'b0, sense_key,
      information, add_sense_length,
      sense_tail};
   wire frame_last = (idx == len - 6'h01);
   wire fire       = (state == SEND) && tx_ready;
   // Abort mid-frame drops the rest of the message
   wire abort      = cmd_cleared || hard_reset;

   assign cmd_ready = (state == IDLE);
   assign tx_valid  = (state == SEND);
   assign tx_last   = (state == SEND) && frame_last;

   status_byte_mux u_mux (
      .idx      (idx),
      .tag      (tag),
      .status   (status),
      .flag     (flag),
      .link     (link),
      .ret_code (ret_code),
      .sense    (sense),
      .byte_out (mux_byte)
   );
   assign tx_data = mux_byte;

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= IDLE;
         idx   <= 6'h00;
      end else if (state == SEND && abort) begin
         state <= IDLE;
         idx   <= 6'h00;
      end else if (accept) begin
         state <= SEND;
         idx   <= 6'h00;
      end else if (fire) begin
         idx   <= frame_last ? 6'h00 : 6'(idx + 6'h01);
         if (frame_last) state <= IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tag            <= '0;
         status         <= 8'h00;
         flag           <= 1'b0;
         link           <= 1'b0;
         ret_code       <= RC_PARSED_OK;
         sense          <= '0;
         len            <= FULL_LEN;
         clear_after    <= 1'b0;
         tx_return_path <= '0;
      end else if (accept) begin
         tag            <= cmd_tag;
         status         <= cmd_status;
         flag           <= next_flag;
         link           <= ctl_link;
         ret_code       <= next_ret_code;
         sense          <= next_sense;
         len            <= next_len;
         clear_after    <= is_check
                           && (add_sense_length < SENSE_FIT_LIMIT);
         tx_return_path <= cmd_return_path;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) sense_clear <= 1'b0;
      else sense_clear <= fire && frame_last && clear_after && !abort;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_header;
      @(posedge ref_clk) disable iff (!rst_b)
      (tx_valid && idx == 6'h00) |-> tx_data == 8'h83;
   endproperty
   a_header: assert property (p_header)
      else $error("byte 0 not message code");

   property p_subcode;
      @(posedge ref_clk) disable iff (!rst_b)
      (tx_valid && idx == 6'h01) |-> tx_data == 8'h11;
   endproperty
   a_subcode: assert property (p_subcode)
      else $error("byte 1 not subcode");

   property p_tag;
      @(posedge ref_clk) disable iff (!rst_b)
      accept |=> (tag == $past(cmd_tag)) throughout (state == SEND)[*1];
   endproperty
   a_tag: assert property (p_tag)
      else $error("tag not captured");

   property p_flaglink;
      @(posedge ref_clk) disable iff (!rst_b)
      (tx_valid && idx == 6'h05) |-> tx_data[7:2] == 6'h00
         && !(tx_data[1] && !tx_data[0]);
   endproperty
   a_flaglink: assert property (p_flaglink)
      else $error("bad flag/link byte");

   property p_retcode;
      @(posedge ref_clk) disable iff (!rst_b)
      (tx_valid && idx == 6'h06) |-> tx_data == 8'h00 || tx_data == 8'hFF;
   endproperty
   a_retcode: assert property (p_retcode)
      else $error("reserved return code");

   property p_invalid;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && out_of_order && confirm_req) |=> ret_code == 8'hFF;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("oot+confirm not invalid");

   property p_reserved7;
      @(posedge ref_clk) disable iff (!rst_b)
      (tx_valid && idx == 6'h07) |-> tx_data == 8'h00;
   endproperty
   a_reserved7: assert property (p_reserved7)
      else $error("byte 7 not zero");

   property p_noreject;
      @(posedge ref_clk) disable iff (!rst_b)
      (state == IDLE && (cmd_rejected || cmd_cleared || hard_reset))
         |=> state == IDLE;
   endproperty
   a_noreject: assert property (p_noreject)
      else $error("frame started for rejected command");

   property p_checklen;
      @(posedge ref_clk) disable iff (!rst_b)
      (accept && cmd_status == 8'h02) |=> len == 6'h20;
   endproperty
   a_checklen: assert property (p_checklen)
      else $error("check condition truncated");

   c_short: cover property (@(posedge ref_clk) tx_last && len == 6'h08);
   c_full:  cover property (@(posedge ref_clk) tx_last && len == 6'h20);
   c_clear: cover property (@(posedge ref_clk) sense_clear);
   c_abort: cover property (@(posedge ref_clk) tx_valid && abort);
endmodule : status_msg_builder

/* status_sink.sv */
// Partner model: initiator protocol layer taking status message bytes.
// Assumes one byte moves per edge with tx_valid and tx_ready both high.
`timescale 1ns/1ps
module status_sink (
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_last,
   output logic            tx_ready,
   output logic [7:0]      frame [32],
   output int              last_len,
   output int              nframes,
   output logic            bad_flag
);
   int   idx;
   logic ph;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_ready <= 1'b0;
         ph       <= 1'b0;
         idx      <= 0;
         last_len <= 0;
         nframes  <= 0;
         bad_flag <= 1'b0;
      end else begin
         ph       <= ~ph;
         // Slow mode stalls every other cycle to stretch the frame
         tx_ready <= !slow || ph;
         if (tx_valid && tx_ready) begin
            if (idx < 32) frame[idx] <= tx_data;
            idx <= tx_last ? 0 : idx + 1;
            if (tx_last) begin
               last_len <= idx + 1;
               nframes  <= nframes + 1;
            end
            // Byte 5 is flag/link; flag 1 link 0 is unexpected
            if (idx == 5 && tx_data[1:0] == 2'b10) bad_flag <= 1'b1;
         end else if (!tx_valid) begin
            idx <= 0;
         end
      end
   end
endmodule : status_sink

/* tb.sv */
// Testbench for the status message builder with an initiator model.
// Assumes inputs change on the falling edge of ref_clk.
`timescale 1ns/1ps
module tb;
   import status_msg_pkg::*;
   logic         ref_clk = 0, rst_b = 0, cmd_done = 0, cmd_rejected = 0;
   logic         cmd_cleared = 0, hard_reset = 0, ctl_flag = 0, ctl_link = 0;
   logic         out_of_order = 0, confirm_req = 0, field_invalid = 0;
   logic         short_enable = 0, sense_valid = 0, sense_deferred = 0;
   logic         filemark = 0, end_of_medium_bit = 0, slow = 0;
   logic         incorrect_length_indicator = 0, tx_ready, cmd_ready;
   logic         tx_valid, tx_last, sense_clear, bad_flag;
   logic [15:0]  cmd_tag = 0;
   logic [31:0]  cmd_return_path = 0, information = 0, tx_return_path;
   logic [7:0]   cmd_status = 0, segment_number = 0, add_sense_length = 0;
   logic [7:0]   tx_data;
   logic [3:0]   sense_key = 0;
   logic [127:0] sense_tail = 0;
   logic [7:0]   frame [32];
   int           last_len, nframes, errors = 0, n_checks = 0, n_clear = 0;
   int           i, n0;

   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (sense_clear === 1'b1) n_clear++;

   status_msg_builder status_msg_builder_i (
      .ref_clk                    (ref_clk),
      .rst_b                      (rst_b),
      .cmd_done                   (cmd_done),
      .cmd_rejected               (cmd_rejected),
      .cmd_cleared                (cmd_cleared),
      .hard_reset                 (hard_reset),
      .cmd_tag                    (cmd_tag),
      .cmd_return_path            (cmd_return_path),
      .cmd_status                 (cmd_status),
      .ctl_flag                   (ctl_flag),
      .ctl_link                   (ctl_link),
      .out_of_order               (out_of_order),
      .confirm_req                (confirm_req),
      .field_invalid              (field_invalid),
      .short_enable               (short_enable),
      .sense_valid                (sense_valid),
      .sense_deferred             (sense_deferred),
      .segment_number             (segment_number),
      .filemark                   (filemark),
      .end_of_medium_bit          (end_of_medium_bit),
      .incorrect_length_indicator (incorrect_length_indicator),
      .sense_key                  (sense_key),
      .information                (information),
      .add_sense_length           (add_sense_length),
      .sense_tail                 (sense_tail),
      .tx_ready                   (tx_ready),
      .cmd_ready                  (cmd_ready),
      .tx_valid                   (tx_valid),
      .tx_data                    (tx_data),
      .tx_last                    (tx_last),
      .tx_return_path             (tx_return_path),
      .sense_clear                (sense_clear)
   );
   status_sink status_sink_i (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .slow     (slow),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .tx_ready (tx_ready),
      .frame    (frame),
      .last_len (last_len),
      .nframes  (nframes),
      .bad_flag (bad_flag)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic go();
      @(negedge ref_clk) cmd_done = 1'b1;
      @(negedge ref_clk) cmd_done = 1'b0;
   endtask : go

   task automatic wait_idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wait_idle

   task automatic check_frame(input int len, input logic [7:0] rc);
      int           k;
      logic [255:0] ef;
      ef = {MSG_CODE, PROTOCOL_SUBCODE, cmd_tag, cmd_status, 6'h00,
            ctl_flag & ctl_link, ctl_link, rc, 8'h00, sense_valid,
            sense_deferred ? ERR_CODE_DEFERRED[6:0] : ERR_CODE_CURRENT[6:0],
            segment_number, filemark, end_of_medium_bit,
            incorrect_length_indicator, 1'b0, sense_key, information,
            add_sense_length, sense_tail};
      n0 = nframes;
      go();
      for (k = 0; k < 200 && nframes == n0; k++) @(negedge ref_clk);
      chk(nframes, n0 + 1);
      chk(last_len, len);
      chk(tx_return_path, cmd_return_path);
      for (k = 0; k < len; k++) chk(frame[k], ef[255-8*k -: 8]);
   endtask : check_frame

   task automatic end_of_test();
      if (errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      end_of_test();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      // Short frames over every flag, link and return code case
      for (i = 0; i < 8; i++) begin
         {ctl_flag, ctl_link} = i[1:0];
         {out_of_order, confirm_req} = {i[2], i[0]};
         field_invalid = (i == 6);
         cmd_tag = 16'hA5C3 ^ 16'(i << 9);
         cmd_return_path = 32'h1234_5670 + i;
         short_enable = 1'b1;
         slow = i[0];
         check_frame(8, (i == 5 || i == 6 || i == 7) ? 8'hFF : 8'h00);
      end
      // Full frames with sense data; only the first may clear sense
      {out_of_order, confirm_req} = 2'b00;
      {sense_valid, filemark, incorrect_length_indicator} = 3'b101;
      {segment_number, sense_key, information} = {8'h3C, 4'hB, 32'hDEAD_BEEF};
      sense_tail = {8{16'hF00D}};
      for (i = 0; i < 3; i++) begin
         cmd_status = (i == 2) ? 8'h00 : CHECK_CONDITION;
         short_enable = (i != 2);
         sense_deferred = i[0];
         end_of_medium_bit = i[1];
         add_sense_length = (i == 0) ? 8'h0F : 8'h10;
         check_frame(32, 8'h00);
         wait_idle(3);
      end
      chk(n_clear, 1);
      // Rejected, cleared and hard reset commands give no frame
      n0 = nframes;
      cmd_rejected = 1'b1;
      go();
      chk(tx_valid, 0);
      cmd_rejected = 1'b0;
      go();
      wait_idle(5);
      chk(tx_valid, 1);
      cmd_cleared = 1'b1;
      wait_idle(1);
      chk(tx_valid, 0);
      cmd_cleared = 1'b0;
      go();
      wait_idle(9);
      hard_reset = 1'b1;
      wait_idle(1);
      hard_reset = 1'b0;
      wait_idle(3);
      chk(tx_valid, 0);
      chk(cmd_ready, 1);
      wait_idle(60);
      chk(nframes, n0);
      chk(n_clear, 1);
      // A second command while busy is ignored
      go();
      wait_idle(3);
      chk(cmd_ready, 0);
      go();
      wait_idle(200);
      chk(nframes, n0 + 1);
      chk(bad_flag, 0);
      end_of_test();
   end
endmodule : tb
